// >>> hw/fdh_host.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Write cycle is chip select and write strobe both low together.
// - Read cycle is chip select and output strobe both low together.
// - In multiplexed mode host drives address bits 16..1 while address valid is low.
// - Host makes that edge after reset release, before any access.
// - Serial transfers are whole bytes, most significant bit first.
// - Host issues no access until busy releases.
module fdh_host
  import fdh_pkg::*;
(
  input  wire logic        core_clk,        // System clock, 50 MHz.
  input  wire logic        reset_n,         // Asynchronous reset, active low.
  input  wire logic        reqValid,        // Pulse: access request.
  input  wire logic        reqWrite,        // Request is a write.
  input  wire logic [15:0] reqAddr,         // Word address bits 16..1.
  input  wire logic [15:0] reqData,         // Write data.
  input  wire logic        cfgMuxMode,      // Use multiplexed address/data.
  input  wire logic        cfgNarrow,       // Only twelve address lines wired.
  input  wire logic        bootRestart,     // Pulse: reassert device reset.
  output logic             reqReady,        // Ready for a request.
  output logic             rspValid,        // Pulse: access finished.
  output logic [15:0]      rspData,         // Read data.
  output logic             devReady,        // Device left busy.
  output logic             devIrq,          // Device interrupt seen.
  output logic             devDmaReq,       // Device DMA request seen.
  output logic             reset_in_n,      // Device reset, active low.
  output logic             chipSel_n,       // Chip select, active low.
  output logic             writeStb_n,      // Write strobe, active low.
  output logic             outStb_n,        // Output strobe, active low.
  output logic             address_valid_n, // Address valid, active low.
  output logic [15:0]      addrOut,         // Address lines 16..1.
  output logic [15:0]      dataOut,         // Data lines, driven value.
  output logic             dataOe,          // High while host drives data.
  input  wire logic [15:0] dataIn,          // Data lines, sampled value.
  input  wire logic        busy_n,          // Device busy, active low.
  input  wire logic        irq_n,           // Device interrupt, active low.
  input  wire logic        dma_request_n,   // Device DMA request, active low.
  input  wire logic        spiStart,        // Pulse: start one serial byte.
  input  wire logic [7:0]  spiTx,           // Serial byte to send.
  input  wire logic        spiCpol,         // Serial clock polarity.
  input  wire logic        spiCpha,         // Serial clock phase.
  input  wire logic        spiMiso,         // Serial data from device.
  output logic             spiSclk,         // Serial clock.
  output logic             spiMosi,         // Serial data to device.
  output logic             spiCs_n,         // Serial select, active low.
  output logic             spiBusy,         // Serial byte in progress.
  output logic             spiDone,         // Pulse: serial byte done.
  output logic [7:0]       spiRx            // Serial byte received.
);

  fdh_state_e state;
  fdh_state_e next_state;
  logic [7:0] cnt;
  logic       muxLatched;
  logic       isWrite;
  logic [15:0] addrHold;
  logic [15:0] dataHold;
  // Marks the mode-select pulse after boot, which carries no access.
  logic       avdInit;

  wire        cntDone    = (cnt == 8'h00);
  wire        accept     = (state == ST_IDLE) && reqValid && !bootRestart;
  wire [15:0] mappedAddr = cfgNarrow ? (reqAddr & WIN8K_MASK) : reqAddr;
  wire        busyDone   = busy_n;

  function automatic logic [7:0] widen(input logic [3:0] v);
    widen = {4'h0, v};
  endfunction : widen

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET:     next_state = cntDone ? ST_WAIT_BUSY : ST_RESET;
      // Wait for busy release before any access.
      ST_WAIT_BUSY: next_state = busyDone ? (muxLatched ? ST_AVD_SETUP : ST_IDLE) : ST_WAIT_BUSY;
      ST_IDLE:      next_state = bootRestart ? ST_RESET :
                                 (reqValid ? (muxLatched ? ST_AVD_SETUP : ST_SETUP) : ST_IDLE);
      ST_AVD_SETUP: next_state = cntDone ? ST_AVD_PULSE : ST_AVD_SETUP;
      ST_AVD_PULSE: next_state = cntDone ? (avdInit ? ST_IDLE : ST_SETUP) : ST_AVD_PULSE;
      ST_SETUP:     next_state = cntDone ? ST_STROBE : ST_SETUP;
      ST_STROBE:    next_state = cntDone ? ST_HOLD : ST_STROBE;
      ST_HOLD:      next_state = cntDone ? ST_IDLE : ST_HOLD;
      default:      next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_RESET;
      cnt   <= RESET_CYCLES_C;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        case (next_state)
          ST_RESET:     cnt <= RESET_CYCLES_C;
          ST_AVD_SETUP: cnt <= widen(SETUP_C);
          ST_AVD_PULSE: cnt <= widen(STROBE_C);
          ST_SETUP:     cnt <= widen(SETUP_C);
          ST_STROBE:    cnt <= widen(STROBE_C);
          ST_HOLD:      cnt <= widen(HOLD_C);
          default:      cnt <= 8'h00;
        endcase
      end else if (!cntDone) begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // Mode is captured at reset release and kept until the next reset.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      muxLatched <= 1'b0;
    end else if (state == ST_RESET) begin
      muxLatched <= cfgMuxMode;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      isWrite  <= 1'b0;
      addrHold <= 16'h0000;
      dataHold <= 16'h0000;
      devReady <= 1'b0;
      avdInit  <= 1'b0;
    end else begin
      if (accept) begin
        isWrite  <= reqWrite;
        addrHold <= mappedAddr;
        dataHold <= reqData;
      end
      if (state == ST_RESET || accept) begin
        avdInit <= 1'b0;
      end else if (state == ST_WAIT_BUSY && busyDone && muxLatched) begin
        avdInit <= 1'b1;
      end
      if (state == ST_RESET) begin
        devReady <= 1'b0;
      end else if (state == ST_WAIT_BUSY && busyDone) begin
        devReady <= 1'b1;
      end
    end
  end

  wire inStrobe = (state == ST_STROBE);
  wire inCycle  = (state == ST_SETUP) || inStrobe || (state == ST_HOLD);
  wire inAvd    = (state == ST_AVD_SETUP) || (state == ST_AVD_PULSE);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_in_n      <= 1'b0;
      chipSel_n       <= 1'b1;
      writeStb_n      <= 1'b1;
      outStb_n        <= 1'b1;
      address_valid_n <= 1'b1;
      addrOut         <= 16'h0000;
      dataOut         <= 16'h0000;
      dataOe          <= 1'b0;
      rspValid        <= 1'b0;
      rspData         <= 16'h0000;
      reqReady        <= 1'b0;
      devIrq          <= 1'b0;
      devDmaReq       <= 1'b0;
    end else begin
      reset_in_n      <= (next_state != ST_RESET);
      chipSel_n       <= !(next_state == ST_STROBE);
      writeStb_n      <= !(next_state == ST_STROBE && isWrite);
      outStb_n        <= !(next_state == ST_STROBE && !isWrite);
      // Falling address valid edge with address on the shared lines.
      address_valid_n <= !(next_state == ST_AVD_PULSE && devReady);
      addrOut         <= muxLatched ? 16'h0000 : addrHold;
      dataOut         <= (muxLatched && inAvd) ? addrHold : dataHold;
      dataOe          <= (muxLatched && next_state == ST_AVD_PULSE && devReady) ||
                         (isWrite && (next_state == ST_SETUP || next_state == ST_STROBE ||
                                      next_state == ST_HOLD));
      rspValid        <= (state == ST_HOLD) && cntDone;
      if (inStrobe && cntDone && !isWrite) begin
        rspData <= dataIn;
      end
      reqReady        <= (next_state == ST_IDLE) && !inCycle;
      devIrq          <= !irq_n;
      devDmaReq       <= !dma_request_n;
    end
  end

  fdh_spi_master u_spi (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (spiStart),
    .txByte   (spiTx),
    .cpol     (spiCpol),
    .cpha     (spiCpha),
    .spiMiso  (spiMiso),
    .spiSclk  (spiSclk),
    .spiMosi  (spiMosi),
    .spiCs_n  (spiCs_n),
    .busy     (spiBusy),
    .done     (spiDone),
    .rxByte   (spiRx)
  );

endmodule : fdh_host
`default_nettype wire

// >>> hw/fdh_pkg.sv
package fdh_pkg;

  localparam int        ADDR_W         = 16;
  localparam int        DATA_W         = 16;
  localparam int        RESET_CYCLES   = 8;
  localparam logic [7:0] RESET_CYCLES_C = 8'h08;
  localparam int        SETUP_CYCLES   = 2;
  localparam logic [3:0] SETUP_C        = 4'h2;
  localparam int        STROBE_CYCLES  = 4;
  localparam logic [3:0] STROBE_C       = 4'h4;
  localparam int        HOLD_CYCLES    = 2;
  localparam logic [3:0] HOLD_C         = 4'h2;
  localparam int        SPI_DIV        = 4;
  localparam logic [3:0] SPI_DIV_C      = 4'h4;
  localparam logic [15:0] WIN8K_MASK    = 16'h0FFF;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_WAIT_BUSY,
    ST_IDLE,
    ST_AVD_SETUP,
    ST_AVD_PULSE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } fdh_state_e;

endpackage : fdh_pkg

// >>> hw/fdh_spi_master.sv
`timescale 1ns/100ps
`default_nettype none
module fdh_spi_master
  import fdh_pkg::*;
(
  input  wire logic       core_clk,   // System clock.
  input  wire logic       reset_n,    // Asynchronous reset, active low.
  input  wire logic       start,      // Pulse: shift one byte.
  input  wire logic [7:0] txByte,     // Byte to send.
  input  wire logic       cpol,       // Idle clock level.
  input  wire logic       cpha,       // Sample on second edge when high.
  input  wire logic       spiMiso,    // Serial data from device.
  output logic            spiSclk,    // Serial clock to device.
  output logic            spiMosi,    // Serial data to device.
  output logic            spiCs_n,    // Select, active low.
  output logic            busy,       // Byte in progress.
  output logic            done,       // Pulse: byte finished.
  output logic [7:0]      rxByte      // Received byte.
);

  logic [3:0] divCnt;
  logic [4:0] edgeCnt;
  logic [7:0] txShift;
  wire        tick        = busy && (divCnt == SPI_DIV_C - 4'h1);
  wire        leadingEdge = !edgeCnt[0];
  wire        sampleEdge  = (leadingEdge != cpha);
  wire        lastEdge    = (edgeCnt == 5'h0F);

  // Each byte is sixteen clock edges, most significant bit first.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt  <= 4'h0;
      edgeCnt <= 5'h00;
      txShift <= 8'h00;
      rxByte  <= 8'h00;
      spiSclk <= 1'b0;
      spiMosi <= 1'b0;
      spiCs_n <= 1'b1;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        spiSclk <= cpol;
        if (start) begin
          busy    <= 1'b1;
          spiCs_n <= 1'b0;
          divCnt  <= 4'h0;
          edgeCnt <= 5'h00;
          txShift <= cpha ? txByte : {txByte[6:0], 1'b0};
          spiMosi <= txByte[7];
        end else begin
          spiCs_n <= 1'b1;
        end
      end else begin
        divCnt <= tick ? 4'h0 : divCnt + 4'h1;
        if (tick) begin
          spiSclk <= ~spiSclk;
          edgeCnt <= edgeCnt + 5'h01;
          if (sampleEdge) begin
            rxByte <= {rxByte[6:0], spiMiso};
          end else begin
            spiMosi <= txShift[7];
            txShift <= {txShift[6:0], 1'b0};
          end
          if (lastEdge) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule : fdh_spi_master
`default_nettype wire

// >>> tb/fdh_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fdh_host_sva (
  input wire logic core_clk,        // Clock.
  input wire logic reset_n,         // Reset, active low.
  input wire logic reqReady,        // Ready.
  input wire logic rspValid,        // Done.
  input wire logic devReady,        // Device ready.
  input wire logic reset_in_n,      // Device reset.
  input wire logic chipSel_n,       // Select.
  input wire logic writeStb_n,      // Write strobe.
  input wire logic outStb_n,        // Output strobe.
  input wire logic address_valid_n, // Address valid.
  input wire logic dataOe           // Host drives data.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_write_cycle: assert property (!writeStb_n |-> !chipSel_n && outStb_n)
    else $error("write strobe outside select");
  a_read_cycle: assert property (!outStb_n |-> !chipSel_n && !dataOe)
    else $error("read strobe wrong");
  a_strobe_width: assert property ($fell(chipSel_n) |-> !chipSel_n [*5] ##1 chipSel_n)
    else $error("select width wrong");
  a_rsp_after: assert property ($rose(chipSel_n) |-> ##[0:6] rspValid)
    else $error("no response after cycle");
  a_busy_gate: assert property (!devReady |-> chipSel_n && address_valid_n)
    else $error("access while busy");
  a_ready_gate: assert property (reqReady |-> devReady)
    else $error("ready before device");
  a_dev_reset: assert property ($rose(reset_n) |-> !reset_in_n [*7])
    else $error("device reset too short");
  a_reset_quiet: assert property (!reset_in_n |-> chipSel_n && !reqReady)
    else $error("access in device reset");
  a_avd_drive: assert property (!address_valid_n |-> dataOe)
    else $error("address not driven");
endmodule : fdh_host_sva
`default_nettype wire

// >>> tb/fdh_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module fdh_dev_model (
  input wire logic        core_clk, reset_in_n, chipSel_n, writeStb_n, outStb_n, // Bus.
  input wire logic        address_valid_n, dataOe, narrow, cpol, cpha, dmaAsk,  // Ctrl.
  input wire logic [15:0] addrOut, dataOut,                                      // Lines.
  input wire logic        spiSclk, spiMosi, spiCs_n,                             // Serial.
  output logic [15:0]     dataIn,                                                // Bus.
  output logic            busy_n, irq_n, dma_request_n, spiMiso                  // Flags.
);
  // Storage array stands in for the buffered flash path.
  logic [15:0] mem [0:65535];
  logic        par [0:65535];
  logic [15:0] lat, last = 16'h0000;
  logic        avdQ = 1'b1, csQ = 1'b1, parErr = 1'b0;
  logic        mux;
  int          cnt, sc, mi;
  logic [7:0]  tx = 8'h00, rxByte;
  logic [7:0]  msgs [4] = '{8'hA5, 8'h3C, 8'h81, 8'h5E};
  wire  [15:0] a = (mux ? lat : addrOut) & (narrow ? 16'h0FFF : 16'hFFFF);
  wire         ok = busy_n && (cnt >= 220 || a < 16'h4000);
  wire         rd = !chipSel_n && !outStb_n && ok;
  // A released bus shows a pattern that changes every cycle.
  assign dataIn = dataOe ? dataOut : rd ? mem[a] : ~last;
  assign busy_n = reset_in_n && cnt >= 20;
  assign dma_request_n = !dmaAsk;
  assign spiMiso = spiCs_n ? ~tx[0] : tx[3'(7 - sc)];
  always @(posedge core_clk) last <= dataIn;
  always @(posedge core_clk or negedge reset_in_n) begin
    if (!reset_in_n) begin
      cnt <= 0;
      mux <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      if (cnt < 220) cnt <= cnt + 1;
      avdQ <= address_valid_n;
      csQ <= chipSel_n;
      if (cnt == 1) for (int i = 0; i < 16; i++) begin
        mem[i] <= 16'hB000 | 16'(i);
        par[i] <= ^(16'hB000 | 16'(i));
      end
      if (!address_valid_n && avdQ) mux <= 1'b1;
      if (!address_valid_n) lat <= dataIn;
      if (!chipSel_n && !writeStb_n && ok) begin
        mem[a] <= dataIn;
        par[a] <= ^dataIn;
      end
      if (rd && par[a] !== ^mem[a]) parErr <= 1'b1;
      if (chipSel_n && !csQ) irq_n <= 1'b0;
      else if (!chipSel_n) irq_n <= 1'b1;
    end
  end
  always @(negedge spiCs_n) begin
    tx = msgs[mi];
    mi = (mi + 1) % 4;
    sc = 0;
  end
  always @(spiSclk) if (!spiCs_n) begin
    if ((spiSclk != cpol) ^ cpha) rxByte = {rxByte[6:0], spiMosi};
    if (spiSclk == cpol) sc = sc + 1;
  end
endmodule : fdh_dev_model
`default_nettype wire

// >>> tb/fdh_host_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin error_cnt++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, x, y); end end
module fdh_host_bench;
  import fdh_pkg::*;
  logic core_clk = 0, reset_n = 0, reqValid = 0, reqWrite = 0, cfgMuxMode = 0, cfgNarrow = 0;
  logic bootRestart = 0, spiStart = 0, spiCpol = 0, spiCpha = 0, dmaAsk = 0;
  logic [15:0] reqAddr = 0, reqData = 0, rspData, addrOut, dataOut, dataIn, ad, dd;
  logic [7:0]  spiTx = 0, spiRx, sb;
  logic reqReady, rspValid, devReady, devIrq, devDmaReq, reset_in_n, chipSel_n, writeStb_n;
  logic outStb_n, address_valid_n, dataOe, busy_n, irq_n, dma_request_n, spiMiso, spiSclk;
  logic spiMosi, spiCs_n, spiBusy, spiDone;
  logic [16:0] rq [$], e;
  logic [7:0]  sq [$];
  logic [7:0]  msgs [4] = '{8'hA5, 8'h3C, 8'h81, 8'h5E};
  int error_cnt = 0, checks = 0, seed = 94, n;
  fdh_host dut (.core_clk, .reset_n, .reqValid, .reqWrite, .reqAddr, .reqData, .cfgMuxMode,
    .cfgNarrow, .bootRestart, .reqReady, .rspValid, .rspData, .devReady, .devIrq, .devDmaReq,
    .reset_in_n, .chipSel_n, .writeStb_n, .outStb_n, .address_valid_n, .addrOut, .dataOut,
    .dataOe, .dataIn, .busy_n, .irq_n, .dma_request_n, .spiStart, .spiTx, .spiCpol, .spiCpha,
    .spiMiso, .spiSclk, .spiMosi, .spiCs_n, .spiBusy, .spiDone, .spiRx);
  fdh_dev_model dev (.core_clk, .reset_in_n, .chipSel_n, .writeStb_n, .outStb_n,
    .address_valid_n, .dataOe, .narrow(cfgNarrow), .cpol(spiCpol), .cpha(spiCpha), .dmaAsk,
    .addrOut, .dataOut, .dataIn, .busy_n, .irq_n, .dma_request_n, .spiSclk, .spiMosi,
    .spiCs_n, .spiMiso);
  initial forever #10 core_clk = ~core_clk;
  task automatic acc(input logic w, input logic [15:0] a, d, input logic c);
    @(posedge core_clk);
    #1;
    reqValid = 1; reqWrite = w; reqAddr = a; reqData = d;
    rq.push_back({c, d});
    for (n = 0; n < 50 && reqReady !== 1'b1; n++) @(negedge core_clk);
    @(posedge core_clk);
    #1 reqValid = 0;
    for (n = 0; n < 60 && rspValid !== 1'b1; n++) @(negedge core_clk);
    `CHK(rspValid, 1'b1)
    repeat (2) @(negedge core_clk);
    `CHK(devIrq, 1'b1)
  endtask : acc
  task automatic waitReady();
    for (n = 0; n < 500 && devReady !== 1'b1; n++) @(negedge core_clk);
    `CHK(devReady, 1'b1)
  endtask : waitReady
  task automatic test_done();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  always @(negedge core_clk) begin
    if (rspValid === 1'b1) begin
      e = rq.pop_front();
      if (e[16]) `CHK(rspData, e[15:0])
    end
    if (spiDone === 1'b1) begin
      sb = sq.pop_front();
      `CHK(spiRx, sb)
    end
  end
  initial begin
    #(20000 * 20);
    error_cnt++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1;
    waitReady();
    acc(0, 16'h0003, 16'hB003, 1);
    $display("boot read done");
    repeat (250) @(posedge core_clk);
    for (int k = 0; k < 6; k++) begin
      {ad, dd} = $random(seed);
      cfgNarrow = k[0];
      acc(1, ad, dd, 0);
      acc(0, ad ^ (k[0] ? 16'hF000 : 16'h0000), dd, 1);
    end
    cfgNarrow = 0;
    acc(1, 16'h5000, 16'h2222, 0);
    $display("memory window done");
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      #1 dmaAsk = 1'($random(seed));
      repeat (3) @(posedge core_clk);
      #1 `CHK(devDmaReq, dmaAsk)
    end
    for (int m = 0; m < 8; m++) begin
      @(posedge core_clk);
      #1 {spiCpol, spiCpha} = 2'(m);
      spiTx = 8'($random(seed));
      sq.push_back(msgs[m % 4]);
      @(posedge core_clk);
      #1 spiStart = 1;
      @(posedge core_clk);
      #1 spiStart = 0;
      for (n = 0; n < 200 && spiBusy !== 1'b0; n++) @(negedge core_clk);
      `CHK(dev.rxByte, spiTx)
    end
    $display("serial done");
    @(posedge core_clk);
    #1 cfgMuxMode = 1;
    bootRestart = 1;
    @(posedge core_clk);
    #1 bootRestart = 0;
    repeat (5) @(posedge core_clk);
    waitReady();
    acc(0, 16'h0005, 16'hB005, 1);
    acc(1, 16'h5000, 16'h3333, 0);
    repeat (250) @(posedge core_clk);
    acc(0, 16'h5000, 16'h2222, 1);
    acc(1, 16'h7A31, dd, 0);
    acc(0, 16'h7A31, dd, 1);
    `CHK(dev.mux, 1'b1)
    `CHK(dev.parErr, 1'b0)
    `CHK(rq.size(), 0)
    $display("multiplexed done");
    test_done();
  end
endmodule : fdh_host_bench
bind fdh_host fdh_host_sva chk (.core_clk, .reset_n, .reqReady, .rspValid, .devReady,
  .reset_in_n, .chipSel_n, .writeStb_n, .outStb_n, .address_valid_n, .dataOe);
`default_nettype wire
